// [rtl/okl_pkg.sv]
// Constants, types and timing for the on-site key and LED controller
package okl_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_W = 19;
	localparam int UA_W = 16;
	localparam int CNT_W = 16;
	localparam int FLT_W = 8;

	localparam int HOLD_CAL_S = 3;
	localparam int HOLD_RST_S = 12;
	localparam int CAL_STEADY_S = 1;
	localparam int CAL_FLASH_PERIOD_S = 2;
	localparam int CAL_RUN_MIN = 5;
	localparam logic [MS_W-1:0] HOLD_CAL_MS = MS_W'(HOLD_CAL_S * 1000 / TICK_MS);
	localparam logic [MS_W-1:0] HOLD_RST_MS = MS_W'(HOLD_RST_S * 1000 / TICK_MS);
	localparam logic [MS_W-1:0] CAL_STEADY_MS = MS_W'(CAL_STEADY_S * 1000 / TICK_MS);
	localparam logic [MS_W-1:0] CAL_FLASH_MS = MS_W'(CAL_FLASH_PERIOD_S * 1000 / TICK_MS);
	localparam logic [MS_W-1:0] CAL_RUN_MS = MS_W'(CAL_RUN_MIN * 60 * 1000 / TICK_MS);
	localparam logic [MS_W-1:0] CONFIRM_MS = MS_W'(100 / TICK_MS);
	localparam logic [MS_W-1:0] COUNTDOWN_MS = MS_W'(500 / TICK_MS);
	localparam logic [MS_W-1:0] POWER_SETTLE_MS = MS_W'(100 / TICK_MS);
	localparam logic [MS_W-1:0] SLAVE_WINDOW_MS = MS_W'(125 / TICK_MS);
	localparam logic [FLT_W-1:0] DEBOUNCE_MS = FLT_W'(20 / TICK_MS);

	localparam logic [1:0] RANGE_SEL_EXT_LOW = 2'h1;
	localparam logic [1:0] RANGE_SEL_WIDE = 2'h2;
	localparam logic [UA_W-1:0] STD_LO_UA = 16'h0FA0;
	localparam logic [UA_W-1:0] STD_HI_UA = 16'h5014;
	localparam logic [UA_W-1:0] EXT_LOW_LO_UA = 16'h0ED8;
	localparam logic [UA_W-1:0] EXT_LOW_HI_UA = 16'h5014;
	localparam logic [UA_W-1:0] WIDE_LO_UA = 16'h0F3C;
	localparam logic [UA_W-1:0] WIDE_HI_UA = 16'h5140;
	localparam logic [UA_W-1:0] ALARM_LOW_UA = 16'h0DAC;
	localparam logic [UA_W-1:0] ALARM_HIGH_UA = 16'h55F0;
	localparam int SLAVE_ZERO_UA = 4000;
	localparam int SLAVE_SPAN_UA = 16000;
	localparam int SLAVE_FULL_CNT = 1000;
	localparam int SLAVE_UA_PER_CNT = SLAVE_SPAN_UA / SLAVE_FULL_CNT;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HELD, KEY_WAIT} okl_key_e;
	typedef enum logic [1:0] {CAL_NONE, CAL_EMPTY, CAL_FULL, CAL_BKGND} okl_cal_e;

	typedef struct packed {
		logic bkgnd;
		logic empty;
		logic full;
	} okl_cal_s;

	typedef struct packed {
		logic [UA_W-1:0] lo_ua;
		logic [UA_W-1:0] hi_ua;
	} okl_loop_s;
endpackage

// [rtl/okl_in_filter.sv]
// Three-stage synchroniser with tick-based debounce for one pin
`timescale 1ns/10ps
`default_nettype none
module okl_in_filter (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Millisecond enable and pin
	input wire logic tick_i,
	input wire logic pin_i,
	// Filtered level
	output logic level_o
);
	import okl_pkg::*;

	logic s1;
	logic s2;
	logic s3;
	logic [FLT_W-1:0] cnt;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Level changes only after second and third stage agree for the debounce time
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			level_o <= 1'b0;
		end
		else if (s2 != s3 || s3 == level_o)
			cnt <= '0;
		else if (tick_i)
		begin
			if (cnt >= DEBOUNCE_MS - FLT_W'(1))
			begin
				level_o <= s3;
				cnt <= '0;
			end
			else
				cnt <= cnt + FLT_W'(1);
		end
	end
endmodule
`default_nettype wire

// [rtl/okl_onsite_ctrl.sv]
// On-site key timing, LED sequencing, loop current and supply management
//
// Operation
// - Empty key alone held over 3 s starts empty calibration.
// - Full key alone held over 3 s starts full calibration.
// - Both keys held over 3 s, then released, start background calibration.
// - Both keys held over 12 s restore factory defaults when flashing stops.
// - LED flashes during reset countdown, stops once reset is active.
// - Factory reset erases background, empty and full calibrations.
// - Calibration start: LED steady one second, then flashes with 2 s period.
// - Calibration runs five minutes, then LED flashing stops.
// - LED flashes once briefly after power-up.
// - Every key press gives a confirming LED flash.
// - Lock switch locked rejects parameter writes from communication.
// - Alarm switch keeps software alarm choice or forces low alarm.
// - Three loop ranges: standard, extended low, wide.
// - Failure current is low alarm below 3.6 mA or high above 21.5 mA.
// - Slave mode reports raw pulse count per 125 ms window.
// - Slave loop current maps 0 counts to 4 mA, 1000 to 20 mA.
// - Selecting slave mode completes commissioning at once.
// - Falling supply drops backlight first, radio second, silently; recovery re-enables.
// - Supply insufficient at startup disables backlight, and also radio if radio supply is low, until power cycle.
// - Driving low alarm disables backlight and radio until the low alarm ends.
`timescale 1ns/10ps
`default_nettype none
module okl_onsite_ctrl #(
	parameter int TICK_CYCLES = okl_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Operator keys and switches
	input wire logic KEY_EMPTY_I,
	input wire logic KEY_FULL_I,
	input wire logic LOCK_SW_I,
	input wire logic ALARM_SW_I,
	// Supply comparators
	input wire logic SUPPLY_BACKLIGHT_OK_I,
	input wire logic SUPPLY_RADIO_OK_I,
	// Detector pulses
	input wire logic PULSE_I,
	// Configuration
	input wire logic [1:0] RANGE_SEL_I,
	input wire logic FAIL_HIGH_I,
	input wire logic SLAVE_MODE_I,
	// Measurement path
	input wire logic [okl_pkg::UA_W-1:0] MEAS_UA_I,
	input wire logic MEAS_FAULT_I,
	// Parameter writes from communication
	input wire logic PARAM_WR_I,
	output logic PARAM_ACK_O,
	output logic PARAM_REJ_O,
	// Calibration and reset
	output okl_pkg::okl_cal_s CAL_START_O,
	output logic CAL_ACTIVE_O,
	output logic CAL_DONE_O,
	output okl_pkg::okl_cal_s CAL_VALID_O,
	output logic FACTORY_RESET_O,
	// Status
	output logic LED_O,
	output logic COMMISSION_DONE_O,
	output logic BACKLIGHT_EN_O,
	output logic RADIO_EN_O,
	// Loop and primary value
	output logic [okl_pkg::UA_W-1:0] LOOP_UA_O,
	output okl_pkg::okl_loop_s LOOP_RANGE_O,
	output logic [okl_pkg::CNT_W-1:0] PV_COUNT_O,
	output logic PV_VALID_O
);
	import okl_pkg::*;

	function automatic okl_loop_s range_limits(input logic [1:0] sel);
		okl_loop_s r;
		if (sel == RANGE_SEL_EXT_LOW)
			r = '{lo_ua: EXT_LOW_LO_UA, hi_ua: EXT_LOW_HI_UA};
		else if (sel == RANGE_SEL_WIDE)
			r = '{lo_ua: WIDE_LO_UA, hi_ua: WIDE_HI_UA};
		else
			r = '{lo_ua: STD_LO_UA, hi_ua: STD_HI_UA};
		return r;
	endfunction

	function automatic logic [UA_W-1:0] clamp_ua(input logic [31:0] v, input okl_loop_s lim);
		logic [UA_W-1:0] r;
		if (v < 32'(lim.lo_ua))
			r = lim.lo_ua;
		else if (v > 32'(lim.hi_ua))
			r = lim.hi_ua;
		else
			r = v[UA_W-1:0];
		return r;
	endfunction

	function automatic logic [MS_W-1:0] ms_inc(input logic [MS_W-1:0] v);
		return v + MS_W'(1);
	endfunction

	logic [31:0] div_cnt;
	logic tick;
	logic key_e;
	logic key_f;
	logic key_e_q;
	logic key_f_q;
	logic lock;
	logic alarm_sw;
	logic sup_bl;
	logic sup_rf;
	okl_key_e key_st;
	logic [MS_W-1:0] hold_ms;
	logic both_seen;
	okl_cal_e act_kind;
	logic act_reset;
	logic countdown;
	logic press;
	logic cal_active;
	logic [MS_W-1:0] cal_ms;
	logic [MS_W-1:0] cal_ph;
	okl_cal_e cal_kind;
	logic [MS_W-1:0] flash_ms;
	logic [MS_W-1:0] blink_ms;
	logic next_led;
	logic [MS_W-1:0] settle_ms;
	logic settled;
	logic inhibit_bl;
	logic inhibit_rf;
	logic fail_low;
	logic p1;
	logic p2;
	logic p3;
	logic p4;
	logic [MS_W-1:0] win_ms;
	logic [CNT_W-1:0] acc;

	// Millisecond enable
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			div_cnt <= '0;
			tick <= 1'b0;
		end
		else if (div_cnt >= 32'(TICK_CYCLES - 1))
		begin
			div_cnt <= '0;
			tick <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + 32'h1;
			tick <= 1'b0;
		end
	end

	okl_in_filter u_key_e (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(KEY_EMPTY_I), .level_o(key_e));
	okl_in_filter u_key_f (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(KEY_FULL_I), .level_o(key_f));
	okl_in_filter u_lock (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(LOCK_SW_I), .level_o(lock));
	okl_in_filter u_alarm (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(ALARM_SW_I), .level_o(alarm_sw));
	okl_in_filter u_sup_bl (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(SUPPLY_BACKLIGHT_OK_I),
		.level_o(sup_bl));
	okl_in_filter u_sup_rf (.clk_i(CORE_CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(SUPPLY_RADIO_OK_I),
		.level_o(sup_rf));

	assign press = (key_e & ~key_e_q) | (key_f & ~key_f_q);
	assign countdown = (key_st == KEY_HELD) && both_seen && key_e && key_f;

	// Key hold decision
	always_comb
	begin
		act_kind = CAL_NONE;
		act_reset = 1'b0;
		if (key_st == KEY_HELD)
		begin
			if (both_seen)
			begin
				if (countdown && hold_ms > HOLD_RST_MS)
					act_reset = 1'b1;
				else if (!key_e && !key_f && hold_ms > HOLD_CAL_MS)
					act_kind = CAL_BKGND;
			end
			else if (hold_ms > HOLD_CAL_MS && key_e && !key_f)
				act_kind = CAL_EMPTY;
			else if (hold_ms > HOLD_CAL_MS && key_f && !key_e)
				act_kind = CAL_FULL;
		end
	end

	// Key state and hold timer
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			key_st <= KEY_IDLE;
			hold_ms <= '0;
			both_seen <= 1'b0;
			key_e_q <= 1'b0;
			key_f_q <= 1'b0;
		end
		else
		begin
			key_e_q <= key_e;
			key_f_q <= key_f;
			case (key_st)
				KEY_IDLE:
					if (key_e || key_f)
					begin
						hold_ms <= '0;
						both_seen <= key_e && key_f;
						key_st <= KEY_HELD;
					end
				KEY_HELD:
					if (act_reset || act_kind == CAL_EMPTY || act_kind == CAL_FULL)
						key_st <= KEY_WAIT;
					else if (!key_e && !key_f)
						key_st <= KEY_IDLE;
					else if (key_e && key_f && !both_seen)
					begin
						both_seen <= 1'b1;
						hold_ms <= '0;
					end
					else if (tick && hold_ms <= HOLD_RST_MS)
						hold_ms <= ms_inc(hold_ms);
				default:
					if (!key_e && !key_f)
						key_st <= KEY_IDLE;
			endcase
		end
	end

	// Calibration run timer
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			cal_active <= 1'b0;
			cal_kind <= CAL_NONE;
			cal_ms <= '0;
			cal_ph <= '0;
			CAL_START_O <= '0;
			CAL_DONE_O <= 1'b0;
		end
		else
		begin
			CAL_START_O <= '0;
			CAL_DONE_O <= 1'b0;
			if (act_reset)
				cal_active <= 1'b0;
			else if (act_kind != CAL_NONE && !cal_active)
			begin
				cal_active <= 1'b1;
				cal_kind <= act_kind;
				cal_ms <= '0;
				cal_ph <= '0;
				CAL_START_O <= '{bkgnd: act_kind == CAL_BKGND, empty: act_kind == CAL_EMPTY,
					full: act_kind == CAL_FULL};
			end
			else if (cal_active && tick)
			begin
				if (cal_ms >= CAL_RUN_MS - MS_W'(1))
				begin
					cal_active <= 1'b0;
					CAL_DONE_O <= 1'b1;
				end
				cal_ms <= ms_inc(cal_ms);
				if (cal_ms >= CAL_STEADY_MS)
					cal_ph <= (cal_ph >= CAL_FLASH_MS - MS_W'(1)) ? '0 : ms_inc(cal_ph);
			end
		end
	end

	// Stored calibrations and factory reset
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			CAL_VALID_O <= '0;
			FACTORY_RESET_O <= 1'b0;
		end
		else
		begin
			FACTORY_RESET_O <= act_reset;
			if (act_reset)
				CAL_VALID_O <= '0;
			else if (cal_active && tick && cal_ms >= CAL_RUN_MS - MS_W'(1))
			begin
				if (cal_kind == CAL_BKGND)
					CAL_VALID_O.bkgnd <= 1'b1;
				if (cal_kind == CAL_EMPTY)
					CAL_VALID_O.empty <= 1'b1;
				if (cal_kind == CAL_FULL)
					CAL_VALID_O.full <= 1'b1;
			end
		end
	end

	// Confirm flash and countdown blink timers
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			flash_ms <= CONFIRM_MS;
			blink_ms <= '0;
		end
		else
		begin
			if (press)
				flash_ms <= CONFIRM_MS;
			else if (tick && flash_ms != '0)
				flash_ms <= flash_ms - MS_W'(1);
			if (!countdown)
				blink_ms <= '0;
			else if (tick)
				blink_ms <= (blink_ms >= COUNTDOWN_MS - MS_W'(1)) ? '0 : ms_inc(blink_ms);
		end
	end

	always_comb
	begin
		if (flash_ms != '0)
			next_led = 1'b1;
		else if (countdown)
			next_led = blink_ms < (COUNTDOWN_MS >> 1);
		else if (cal_active && cal_ms < CAL_STEADY_MS)
			next_led = 1'b1;
		else if (cal_active)
			next_led = cal_ph < (CAL_FLASH_MS >> 1);
		else
			next_led = 1'b0;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			LED_O <= 1'b0;
			CAL_ACTIVE_O <= 1'b0;
		end
		else
		begin
			LED_O <= next_led;
			CAL_ACTIVE_O <= cal_active;
		end
	end

	// Parameter write gate
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			PARAM_ACK_O <= 1'b0;
			PARAM_REJ_O <= 1'b0;
		end
		else
		begin
			PARAM_ACK_O <= PARAM_WR_I && !lock;
			PARAM_REJ_O <= PARAM_WR_I && lock;
		end
	end

	// Supply management
	assign fail_low = alarm_sw || !FAIL_HIGH_I;
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			settle_ms <= '0;
			settled <= 1'b0;
			inhibit_bl <= 1'b0;
			inhibit_rf <= 1'b0;
			BACKLIGHT_EN_O <= 1'b0;
			RADIO_EN_O <= 1'b0;
		end
		else
		begin
			if (!settled && tick)
			begin
				settle_ms <= ms_inc(settle_ms);
				if (settle_ms >= POWER_SETTLE_MS - MS_W'(1))
				begin
					settled <= 1'b1;
					inhibit_bl <= !sup_bl || !sup_rf;
					inhibit_rf <= !sup_rf;
				end
			end
			BACKLIGHT_EN_O <= settled && !inhibit_bl && sup_bl && sup_rf && !(MEAS_FAULT_I && fail_low);
			RADIO_EN_O <= settled && !inhibit_rf && sup_rf && !(MEAS_FAULT_I && fail_low);
		end
	end

	// Raw pulse window
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			p1 <= 1'b0;
			p2 <= 1'b0;
			p3 <= 1'b0;
			p4 <= 1'b0;
			win_ms <= '0;
			acc <= '0;
			PV_COUNT_O <= '0;
			PV_VALID_O <= 1'b0;
		end
		else
		begin
			p1 <= PULSE_I;
			p2 <= p1;
			p3 <= p2;
			p4 <= p3;
			PV_VALID_O <= 1'b0;
			if (tick && win_ms >= SLAVE_WINDOW_MS - MS_W'(1))
			begin
				win_ms <= '0;
				PV_COUNT_O <= acc;
				PV_VALID_O <= SLAVE_MODE_I;
				acc <= (p2 == p3 && p3 && !p4) ? CNT_W'(1) : '0;
			end
			else
			begin
				if (tick)
					win_ms <= ms_inc(win_ms);
				if (p2 == p3 && p3 && !p4 && acc != '1)
					acc <= acc + CNT_W'(1);
			end
		end
	end

	// Loop current and commissioning
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			LOOP_UA_O <= ALARM_LOW_UA;
			LOOP_RANGE_O <= '{lo_ua: STD_LO_UA, hi_ua: STD_HI_UA};
			COMMISSION_DONE_O <= 1'b0;
		end
		else
		begin
			LOOP_RANGE_O <= range_limits(RANGE_SEL_I);
			if (MEAS_FAULT_I)
				LOOP_UA_O <= fail_low ? ALARM_LOW_UA : ALARM_HIGH_UA;
			else if (SLAVE_MODE_I)
				LOOP_UA_O <= clamp_ua(32'(SLAVE_ZERO_UA) + 32'(PV_COUNT_O) * 32'(SLAVE_UA_PER_CNT),
					range_limits(RANGE_SEL_I));
			else
				LOOP_UA_O <= clamp_ua(32'(MEAS_UA_I), range_limits(RANGE_SEL_I));
			if (SLAVE_MODE_I)
				COMMISSION_DONE_O <= 1'b1;
			else if (act_reset)
				COMMISSION_DONE_O <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [tb/okl_onsite_ctrl_checker.sv]
// Port-level assertions for the on-site key and LED controller
`timescale 1ns/10ps
`default_nettype none
module okl_onsite_ctrl_checker #(
	parameter int TICK_CYCLES = 4
) (
	// Clock, reset and inputs
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic PARAM_WR_I,
	input wire logic SLAVE_MODE_I,
	input wire logic MEAS_FAULT_I,
	// Observed outputs
	input wire logic PARAM_ACK_O,
	input wire logic PARAM_REJ_O,
	input wire okl_pkg::okl_cal_s CAL_START_O,
	input wire logic CAL_ACTIVE_O,
	input wire logic CAL_DONE_O,
	input wire okl_pkg::okl_cal_s CAL_VALID_O,
	input wire logic FACTORY_RESET_O,
	input wire logic LED_O,
	input wire logic BACKLIGHT_EN_O,
	input wire logic RADIO_EN_O,
	input wire logic [okl_pkg::UA_W-1:0] LOOP_UA_O,
	input wire logic [okl_pkg::CNT_W-1:0] PV_COUNT_O,
	input wire logic PV_VALID_O
);
	import okl_pkg::*;
	logic [1:0] since_rst;
	int cal_age;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// Edges since reset, so registered outputs have settled
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
		if (RST_I)
			since_rst <= 2'h0;
		else if (since_rst != 2'h3)
			since_rst <= since_rst + 2'h1;
	// Age of the running calibration
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
		if (RST_I)
			cal_age <= 0;
		else if (!CAL_ACTIVE_O)
			cal_age <= 0;
		else if (cal_age < 100000)
			cal_age <= cal_age + 1;
	property p_param_answer;
		(PARAM_ACK_O || PARAM_REJ_O) == $past(PARAM_WR_I) && !(PARAM_ACK_O && PARAM_REJ_O);
	endproperty
	a_param_answer: assert property (p_param_answer) else $error("write answer wrong");
	property p_cal_start;
		|CAL_START_O |-> $onehot(CAL_START_O) ##1 CAL_START_O == 3'h0 ##[0:1] CAL_ACTIVE_O;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("bad calibration start");
	property p_cal_steady;
		CAL_ACTIVE_O && cal_age > 2 * TICK_CYCLES && cal_age < 990 * TICK_CYCLES |-> LED_O;
	endproperty
	a_cal_steady: assert property (p_cal_steady) else $error("LED not steady");
	property p_reset_clear;
		FACTORY_RESET_O |-> ##[0:1] (CAL_VALID_O == 3'h0 && !CAL_ACTIVE_O);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset kept state");
	property p_reset_led;
		FACTORY_RESET_O |-> ##2 !LED_O [*8];
	endproperty
	a_reset_led: assert property (p_reset_led) else $error("LED still flashing");
	property p_done;
		CAL_DONE_O |-> ##[0:1] !CAL_ACTIVE_O;
	endproperty
	a_done: assert property (p_done) else $error("calibration still active");
	property p_powerup;
		$fell(RST_I) |-> ##3 LED_O [*8];
	endproperty
	a_powerup: assert property (p_powerup) else $error("no power-up flash");
	property p_fault_alarm;
		since_rst == 2'h3 && $past(MEAS_FAULT_I) |-> LOOP_UA_O == ALARM_LOW_UA || LOOP_UA_O == ALARM_HIGH_UA;
	endproperty
	a_fault_alarm: assert property (p_fault_alarm) else $error("no alarm current");
	property p_slave_loop;
		since_rst == 2'h3 && $past(SLAVE_MODE_I) && !$past(MEAS_FAULT_I) && $stable(PV_COUNT_O)
			&& PV_COUNT_O < 16'h0384 |-> LOOP_UA_O == UA_W'(SLAVE_ZERO_UA + SLAVE_UA_PER_CNT * PV_COUNT_O);
	endproperty
	a_slave_loop: assert property (p_slave_loop) else $error("slave loop mapping wrong");
	property p_pv_slave;
		PV_VALID_O |-> $past(SLAVE_MODE_I) ##1 !PV_VALID_O [*8];
	endproperty
	a_pv_slave: assert property (p_pv_slave) else $error("count outside slave mode");
	property p_shed_order;
		BACKLIGHT_EN_O |-> RADIO_EN_O;
	endproperty
	a_shed_order: assert property (p_shed_order) else $error("backlight on without radio");
endmodule
bind okl_onsite_ctrl okl_onsite_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_okl_onsite_ctrl_checker (.*);
`default_nettype wire

// [tb/okl_field_model.sv]
// Operator keys, detector pulse source and loop evaluation unit
`timescale 1ns/10ps
`default_nettype none
module okl_field_model (
	// Clock
	input wire logic clk_i,
	// Commands from the bench
	input wire logic [1:0] key_cmd_i,
	input wire logic pulse_en_i,
	// Loop current to evaluate
	input wire logic [okl_pkg::UA_W-1:0] loop_ua_i,
	// Pins towards the device
	output logic key_empty_o,
	output logic key_full_o,
	output logic pulse_o,
	// Evaluation result
	output logic alarm_o
);
	import okl_pkg::*;
	logic [3:0] phase = 4'h0;
	always_ff @(posedge clk_i)
		phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
	// Ten-cycle pulse train, one rising edge each
	assign pulse_o = pulse_en_i && phase < 4'h5;
	// Contacts held steady for the whole press
	assign key_empty_o = key_cmd_i[0];
	assign key_full_o = key_cmd_i[1];
	// Flags currents below 3.6 mA or above 21.5 mA
	assign alarm_o = loop_ua_i < 16'h0E10 || loop_ua_i > 16'h53FC;
endmodule
`default_nettype wire

// [tb/okl_onsite_ctrl_tb.sv]
// Self-checking bench for the on-site key and LED controller
`timescale 1ns/10ps
`default_nettype none
module okl_onsite_ctrl_tb;
	import okl_pkg::*;
	localparam int TK = 4;
	localparam logic [15:0] LO_TAB [4] = '{STD_LO_UA, EXT_LOW_LO_UA, WIDE_LO_UA, STD_LO_UA};
	localparam logic [15:0] HI_TAB [4] = '{STD_HI_UA, EXT_LOW_HI_UA, WIDE_HI_UA, STD_HI_UA};
	logic CORE_CLK_I = 1'b0, RST_I = 1'b1, LOCK_SW_I = 1'b0, ALARM_SW_I = 1'b0;
	logic SUPPLY_BACKLIGHT_OK_I = 1'b1, SUPPLY_RADIO_OK_I = 1'b1, FAIL_HIGH_I = 1'b0;
	logic SLAVE_MODE_I = 1'b0, MEAS_FAULT_I = 1'b0, PARAM_WR_I = 1'b0, pulse_en = 1'b0;
	logic [1:0] RANGE_SEL_I = 2'h0, key_cmd = 2'h0;
	logic [UA_W-1:0] MEAS_UA_I = 16'h2710;
	logic KEY_EMPTY_I, KEY_FULL_I, PULSE_I, alarm, led_q = 1'b0;
	logic PARAM_ACK_O, PARAM_REJ_O, CAL_ACTIVE_O, CAL_DONE_O, FACTORY_RESET_O, LED_O;
	logic COMMISSION_DONE_O, BACKLIGHT_EN_O, RADIO_EN_O, PV_VALID_O;
	okl_cal_s CAL_START_O, CAL_VALID_O, last_start;
	okl_loop_s LOOP_RANGE_O;
	logic [UA_W-1:0] LOOP_UA_O;
	logic [CNT_W-1:0] PV_COUNT_O;
	int err_total = 0, check_count = 0, cycles = 0, start_cnt = 0, fr_cnt = 0, led_cnt = 0, pv_seen = 0;
	okl_onsite_ctrl #(.TICK_CYCLES(TK)) i_okl_onsite_ctrl (.*);
	okl_field_model i_okl_field_model (.clk_i(CORE_CLK_I), .key_cmd_i(key_cmd), .pulse_en_i(pulse_en),
		.loop_ua_i(LOOP_UA_O), .key_empty_o(KEY_EMPTY_I), .key_full_o(KEY_FULL_I), .pulse_o(PULSE_I),
		.alarm_o(alarm));
	always #10 CORE_CLK_I = ~CORE_CLK_I;
	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(negedge CORE_CLK_I);
	endtask
	task automatic wr(input logic acc);
		PARAM_WR_I = 1'b1;
		@(negedge CORE_CLK_I);
		PARAM_WR_I = 1'b0;
		chk({PARAM_ACK_O, PARAM_REJ_O}, {acc, !acc});
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	// Event counters and run limit
	always @(posedge CORE_CLK_I)
	begin
		cycles++;
		start_cnt += |CAL_START_O;
		if (|CAL_START_O)
			last_start = CAL_START_O;
		fr_cnt += FACTORY_RESET_O;
		led_cnt += LED_O && !led_q;
		led_q = LED_O;
		pv_seen += PV_VALID_O;
		if (cycles == 95000)
		begin
			err_total++;
			close_out();
		end
	end
	initial
	begin
		repeat (6) @(negedge CORE_CLK_I);
		RST_I = 1'b0;
		ms(5);
		chk(LED_O, 1'b1);
		chk(LOOP_RANGE_O, {STD_LO_UA, STD_HI_UA});
		wr(1'b1);
		LOCK_SW_I = 1'b1;
		ms(30);
		wr(1'b0);
		LOCK_SW_I = 1'b0;
		done("power-up and lock");
		for (int s = 0; s < 4; s++)
		begin
			RANGE_SEL_I = 2'(s);
			MEAS_UA_I = 16'h0000;
			ms(1);
			chk(LOOP_UA_O, LO_TAB[s]);
			MEAS_UA_I = 16'hFFFF;
			ms(1);
			chk(LOOP_UA_O, HI_TAB[s]);
		end
		RANGE_SEL_I = 2'h0;
		ms(120);
		MEAS_FAULT_I = 1'b1;
		FAIL_HIGH_I = 1'b1;
		ms(1);
		chk(LOOP_UA_O, ALARM_HIGH_UA);
		chk(alarm, 1'b1);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h3);
		FAIL_HIGH_I = 1'b0;
		ms(1);
		chk(LOOP_UA_O, ALARM_LOW_UA);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h0);
		FAIL_HIGH_I = 1'b1;
		ALARM_SW_I = 1'b1;
		ms(30);
		chk(LOOP_UA_O, ALARM_LOW_UA);
		MEAS_FAULT_I = 1'b0;
		ALARM_SW_I = 1'b0;
		ms(30);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h3);
		SUPPLY_BACKLIGHT_OK_I = 1'b0;
		ms(30);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h1);
		SUPPLY_RADIO_OK_I = 1'b0;
		ms(30);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h0);
		SUPPLY_BACKLIGHT_OK_I = 1'b1;
		SUPPLY_RADIO_OK_I = 1'b1;
		ms(30);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h3);
		done("loop and supply");
		SLAVE_MODE_I = 1'b1;
		pulse_en = 1'b1;
		pv_seen = 0;
		for (int i = 0; i < 2000 && pv_seen < 3; i++)
			@(negedge CORE_CLK_I);
		ms(1);
		chk(PV_COUNT_O, 125 * TK / 10);
		chk(LOOP_UA_O, SLAVE_ZERO_UA + SLAVE_UA_PER_CNT * 125 * TK / 10);
		chk(COMMISSION_DONE_O, 1'b1);
		SLAVE_MODE_I = 1'b0;
		pulse_en = 1'b0;
		done("slave");
		start_cnt = 0;
		led_cnt = 0;
		key_cmd = 2'h2;
		ms(1000);
		key_cmd = 2'h0;
		ms(50);
		chk(start_cnt, 0);
		chk(led_cnt > 0, 1'b1);
		key_cmd = 2'h3;
		ms(4000);
		chk(start_cnt, 0);
		key_cmd = 2'h0;
		ms(50);
		chk(last_start, 3'h4);
		chk(CAL_ACTIVE_O, 1'b1);
		// Steady second over before the countdown blink starts
		ms(1000);
		led_cnt = 0;
		key_cmd = 2'h3;
		ms(12100);
		chk(fr_cnt, 1);
		chk(led_cnt > 20, 1'b1);
		chk({CAL_ACTIVE_O, CAL_VALID_O}, 4'h0);
		key_cmd = 2'h0;
		ms(50);
		chk(start_cnt, 1);
		key_cmd = 2'h1;
		ms(3000);
		chk(start_cnt, 1);
		ms(60);
		chk(last_start, 3'h2);
		ms(500);
		chk(LED_O, 1'b1);
		key_cmd = 2'h0;
		done("keys");
		RST_I = 1'b1;
		SUPPLY_RADIO_OK_I = 1'b0;
		repeat (6) @(negedge CORE_CLK_I);
		RST_I = 1'b0;
		ms(150);
		SUPPLY_RADIO_OK_I = 1'b1;
		ms(50);
		chk({BACKLIGHT_EN_O, RADIO_EN_O}, 2'h0);
		done("weak start");
		close_out();
	end
endmodule
`default_nettype wire
